// file: logic/wdtu_pkg.sv
// package: constants, register map and carrier types of the watchdog timer unit
package wdtu_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_STATUS  = 8'h04;
    localparam logic [7:0] ADDR_CONFIG  = 8'h08;

    // ------------------------------------------------------------
    // control register layout and reset value
    // ------------------------------------------------------------
    localparam int          CTL_KEEP_BIT = 7;
    localparam int          CTL_SEL_LSB  = 4;
    localparam int          CTL_KEY_LSB  = 0;
    localparam logic [7:0]  CTL_RESET    = 8'h7A;
    localparam logic [3:0]  KEY_DISABLE  = 4'hA;

    // ------------------------------------------------------------
    // status bits
    // ------------------------------------------------------------
    localparam int STS_EXPIRED = 0;
    localparam int STS_PDOWN   = 1;
    localparam int STS_FAST_OK = 2;
    localparam int STS_SLOW_OK = 3;
    localparam int STS_ENABLED = 4;

    // ------------------------------------------------------------
    // config bits (option word)
    // ------------------------------------------------------------
    localparam int CFG_SRC_SYS   = 0;
    localparam int CFG_SUB_IRC   = 1;
    localparam int CFG_PAIRED    = 2;
    localparam int CFG_OPT_DIS   = 3;
    localparam int CFG_FAST_WAKE = 4;
    localparam int CFG_LOW_CORE  = 5;
    localparam logic [5:0] CFG_RESET = 6'h00;

    // ------------------------------------------------------------
    // counting
    // ------------------------------------------------------------
    localparam int          CNT_W        = 20;
    localparam int          SEL_BASE     = 12;
    localparam logic [1:0]  SYS_DIV_LAST = 2'h3;
    localparam logic [10:0] XTAL_STARTUP = 11'h400;

    typedef enum logic [1:0] {
        WDTU_RUN,
        WDTU_DEEP,
        WDTU_IDLE_OFF,
        WDTU_IDLE_ON
    } wdtu_mode_t;

    typedef enum logic [1:0] {
        WDTU_SU_IDLE,
        WDTU_SU_FAST,
        WDTU_SU_SLOW
    } wdtu_su_t;

    // instruction pulses from the core
    typedef struct packed {
        logic clr_single;
        logic clr_first;
        logic clr_second;
        logic halt;
        logic idle_sel;
        logic wake;
    } wdtu_instr_t;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } wdtu_apb_rsp_t;

endpackage

// file: logic/wdtu_startup.sv
// shared start-up counter for the fast and slow crystal oscillators
`timescale 1ns/1ps
module wdtu_startup (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_sys_rst,
    // request and oscillator ticks
    input  wire logic i_start,
    input  wire logic i_fast_tick,
    input  wire logic i_slow_tick,
    // ready flags
    output logic      o_fast_ok,
    output logic      o_slow_ok
);
    typedef struct packed {
        wdtu_pkg::wdtu_su_t st;
        logic [10:0]        cnt;
        logic               fast_ok;
        logic               slow_ok;
    } wdtu_su_state_t;

    wdtu_su_state_t r;
    wdtu_su_state_t next_r;

    always_comb begin
        next_r = r;
        case (r.st)
            wdtu_pkg::WDTU_SU_IDLE: begin
                if (i_start) begin
                    next_r.st      = wdtu_pkg::WDTU_SU_FAST;
                    next_r.cnt     = '0;
                    next_r.fast_ok = 1'b0;
                    next_r.slow_ok = 1'b0;
                end
            end
            wdtu_pkg::WDTU_SU_FAST: begin
                if (i_fast_tick) begin
                    next_r.cnt = r.cnt + 11'h001;
                end
                if (r.cnt == wdtu_pkg::XTAL_STARTUP) begin
                    // slow crystal takes the counter only after the fast one is done
                    next_r.fast_ok = 1'b1;
                    next_r.cnt     = '0;
                    next_r.st      = wdtu_pkg::WDTU_SU_SLOW;
                end
            end
            wdtu_pkg::WDTU_SU_SLOW: begin
                if (i_slow_tick) begin
                    next_r.cnt = r.cnt + 11'h001;
                end
                if (r.cnt == wdtu_pkg::XTAL_STARTUP) begin
                    next_r.slow_ok = 1'b1;
                    next_r.st      = wdtu_pkg::WDTU_SU_IDLE;
                end
            end
            default: next_r.st = wdtu_pkg::WDTU_SU_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            r <= '{st: wdtu_pkg::WDTU_SU_FAST, cnt: 11'h000, fast_ok: 1'b0, slow_ok: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    assign o_fast_ok = r.fast_ok;
    assign o_slow_ok = r.slow_ok;
endmodule

// file: logic/wdtu_top.sv
// watchdog timer unit: APB registers, clock selection, counter, clear schemes and expiry actions
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps
module wdtu_top (
    // clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_sys_rst,
    // apb slave
    input  wire logic                 i_psel,
    input  wire logic                 i_penable,
    input  wire logic                 i_pwrite,
    input  wire logic [7:0]           i_paddr,
    input  wire logic [31:0]          i_pwdata,
    output logic                      o_pready,
    output logic [31:0]               o_prdata,
    output logic                      o_pslverr,
    // core instructions and external clear pin
    input  wire wdtu_pkg::wdtu_instr_t i_instr,
    input  wire logic                 i_ext_clear_pin_n,
    // clock ticks
    input  wire logic                 i_core_tick,
    input  wire logic                 i_high_tick,
    input  wire logic                 i_low_xtal_tick,
    input  wire logic                 i_low_irc_tick,
    // actions toward the core
    output logic                      o_device_reset,
    output logic                      o_pc_stack_clear,
    output logic                      o_core_run,
    output logic                      o_core_clock_on,
    output logic                      o_core_slow_allowed
);
    typedef struct packed {
        logic [7:0]           ctl;
        logic [5:0]           cfg;
        logic [19:0]          cnt;
        logic [1:0]           div;
        logic                 last_first;
        logic                 last_valid;
        logic                 expired;
        logic                 pdown;
        wdtu_pkg::wdtu_mode_t mode;
        logic                 wake_deep;
        logic                 fs_start;
        wdtu_pkg::wdtu_apb_rsp_t apb;
        logic                 dev_rst;
        logic                 pcs_clr;
        logic                 run;
        logic                 clk_on;
        logic                 slow_ok;
    } wdtu_state_t;

    wdtu_state_t r;
    wdtu_state_t next_r;
    logic        fast_ok;
    logic        slow_xtal_ok;

    // ------------------------------------------------------------
    // shared start-up counter
    // ------------------------------------------------------------
    wdtu_startup u_startup (
        .i_clk       (i_clk),
        .i_sys_rst   (i_sys_rst),
        .i_start     (r.fs_start),
        .i_fast_tick (i_high_tick),
        .i_slow_tick (i_low_xtal_tick),
        .o_fast_ok   (fast_ok),
        .o_slow_ok   (slow_xtal_ok)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic        enabled;
    logic        sub_tick;
    logic        src_tick;
    logic        sys_tick;
    logic        clr_ok;
    logic        overflow;
    logic [2:0]  sel;
    logic [19:0] limit;
    logic        setup;
    logic        access;

    always_comb begin
        next_r   = r;
        sel      = r.ctl[wdtu_pkg::CTL_SEL_LSB +: 3];
        enabled  = !(r.cfg[wdtu_pkg::CFG_OPT_DIS]
                    && r.ctl[wdtu_pkg::CTL_KEY_LSB +: 4] == wdtu_pkg::KEY_DISABLE);
        sub_tick = r.cfg[wdtu_pkg::CFG_SUB_IRC] ? i_low_irc_tick : i_low_xtal_tick;
        // core tick already reflects a fast/slow switch of the core clock
        sys_tick = 1'b0;
        if (i_core_tick && r.clk_on) begin
            next_r.div = r.div + 2'h1;
            sys_tick   = (r.div == wdtu_pkg::SYS_DIV_LAST);
        end
        src_tick = r.cfg[wdtu_pkg::CFG_SRC_SYS] ? sys_tick : sub_tick;
        setup    = i_psel && !i_penable;
        access   = i_psel && i_penable;

        // clear instruction decode
        clr_ok = 1'b0;
        if (enabled) begin
            if (!r.cfg[wdtu_pkg::CFG_PAIRED]) begin
                clr_ok = i_instr.clr_single;
            end else if (i_instr.clr_first || i_instr.clr_second) begin
                clr_ok = !r.last_valid || (r.last_first != i_instr.clr_first);
                next_r.last_first = i_instr.clr_first;
                next_r.last_valid = 1'b1;
            end
            if (clr_ok) begin
                next_r.pdown = 1'b0;
            end
        end

        // counter
        next_r.dev_rst = 1'b0;
        next_r.pcs_clr = 1'b0;
        // terminal count is 2^(13+sel)-1: every bit below 13+sel set
        limit          = 20'hFFFFF >> (wdtu_pkg::CNT_W - 1 - wdtu_pkg::SEL_BASE - sel);
        overflow       = enabled && src_tick && (r.cnt == limit);
        if (!enabled || clr_ok || !i_ext_clear_pin_n || i_instr.halt) begin
            next_r.cnt = '0;
        end else if (overflow) begin
            next_r.cnt     = '0;
            next_r.expired = 1'b1;
            if (r.mode == wdtu_pkg::WDTU_RUN) begin
                next_r.dev_rst = 1'b1;
            end else begin
                next_r.pcs_clr = 1'b1;
                next_r.mode    = wdtu_pkg::WDTU_RUN;
                next_r.clk_on  = 1'b1;
                next_r.run     = 1'b1;
            end
        end else if (src_tick) begin
            next_r.cnt = r.cnt + 20'h00001;
        end

        // halt enters a power mode
        if (i_instr.halt && r.mode == wdtu_pkg::WDTU_RUN) begin
            next_r.pdown   = 1'b1;
            next_r.expired = 1'b0;
            next_r.run     = 1'b0;
            if (!i_instr.idle_sel) begin
                next_r.mode   = wdtu_pkg::WDTU_DEEP;
                next_r.clk_on = 1'b0;
            end else if (r.ctl[wdtu_pkg::CTL_KEEP_BIT]) begin
                next_r.mode   = wdtu_pkg::WDTU_IDLE_ON;
                next_r.clk_on = 1'b1;
            end else begin
                next_r.mode   = wdtu_pkg::WDTU_IDLE_OFF;
                next_r.clk_on = 1'b0;
            end
        end

        // wake-up
        next_r.fs_start = 1'b0;
        if (i_instr.wake && r.mode != wdtu_pkg::WDTU_RUN) begin
            next_r.mode      = wdtu_pkg::WDTU_RUN;
            next_r.clk_on    = 1'b1;
            next_r.wake_deep = (r.mode == wdtu_pkg::WDTU_DEEP);
            next_r.fs_start  = (r.mode == wdtu_pkg::WDTU_DEEP);
            next_r.run       = (r.mode != wdtu_pkg::WDTU_DEEP);
            next_r.slow_ok   = r.cfg[wdtu_pkg::CFG_FAST_WAKE] && !enabled
                               || r.cfg[wdtu_pkg::CFG_FAST_WAKE];
        end
        if (r.wake_deep && fast_ok && !r.fs_start) begin
            next_r.run       = 1'b1;
            next_r.wake_deep = 1'b0;
        end

        // apb slave: one wait-free access phase
        next_r.apb.pready  = 1'b0;
        next_r.apb.pslverr = 1'b0;
        if (setup) begin
            next_r.apb.pready = 1'b1;
            case (i_paddr)
                wdtu_pkg::ADDR_CONTROL: next_r.apb.prdata = {24'h000000, r.ctl};
                wdtu_pkg::ADDR_STATUS:  next_r.apb.prdata = {27'h0000000, enabled, slow_xtal_ok,
                                                             fast_ok, r.pdown, r.expired};
                wdtu_pkg::ADDR_CONFIG:  next_r.apb.prdata = {26'h0000000, r.cfg};
                default: begin
                    next_r.apb.prdata  = 32'h00000000;
                    next_r.apb.pslverr = 1'b1;
                end
            endcase
        end
        if (access && r.apb.pready && i_pwrite) begin
            case (i_paddr)
                wdtu_pkg::ADDR_CONTROL: next_r.ctl = i_pwdata[7:0];
                wdtu_pkg::ADDR_CONFIG:  next_r.cfg = i_pwdata[5:0];
                default: next_r.ctl = next_r.ctl;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            r            <= '0;
            r.ctl        <= wdtu_pkg::CTL_RESET;
            r.cfg        <= wdtu_pkg::CFG_RESET;
            r.mode       <= wdtu_pkg::WDTU_RUN;
            r.run        <= 1'b1;
            r.clk_on     <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_pready            = r.apb.pready;
    assign o_prdata            = r.apb.prdata;
    assign o_pslverr           = r.apb.pslverr;
    assign o_device_reset      = r.dev_rst;
    assign o_pc_stack_clear    = r.pcs_clr;
    assign o_core_run          = r.run;
    assign o_core_clock_on     = r.clk_on;
    assign o_core_slow_allowed = r.slow_ok;
endmodule

// file: tb/testbench.sv
// self-checking testbench of the watchdog timer unit
`timescale 1ns/1ps
module testbench;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam logic [5:0] OP_SINGLE = 6'h20;
    localparam logic [5:0] OP_FIRST  = 6'h10;
    localparam logic [5:0] OP_SECOND = 6'h08;
    localparam logic [5:0] OP_DEEP   = 6'h04;
    localparam logic [5:0] OP_IDLE   = 6'h06;
    localparam logic [5:0] OP_WAKE   = 6'h01;
    localparam int         LIMIT     = 99000;
    localparam logic [7:0] A_CTL     = wdtu_pkg::ADDR_CONTROL;
    localparam logic [7:0] A_STS     = wdtu_pkg::ADDR_STATUS;
    localparam logic [7:0] A_CFG     = wdtu_pkg::ADDR_CONFIG;
    logic                  clk, rst, psel, penable, pwrite, pready, pslverr, ext_n, err;
    logic                  core_t, high_t, xtal_t, irc_t, dev_rst, pcs, run, clk_on, slow;
    logic [7:0]            paddr;
    logic [31:0]           pwdata, prdata, v;
    int                    failures, num_checks, cycles, ar, ap, n;
    wdtu_pkg::wdtu_instr_t instr;

    wdtu_top u_dut (
        .i_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
        .i_instr(instr), .i_ext_clear_pin_n(ext_n), .i_core_tick(core_t), .i_high_tick(high_t),
        .i_low_xtal_tick(xtal_t), .i_low_irc_tick(irc_t), .o_device_reset(dev_rst),
        .o_pc_stack_clear(pcs), .o_core_run(run), .o_core_clock_on(clk_on), .o_core_slow_allowed(slow)
    );
    wdtu_core_model u_core (
        .i_clk(clk),
        .o_instr(instr)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            failures++;
            end_sim();
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic end_sim();
        if (failures == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr_en;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        v   = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(nm, v & mask, exp);
    endtask

    task automatic setup(input logic [31:0] ctl, input logic [31:0] cfg);
        apb(1'b1, A_CTL, ctl);
        apb(1'b1, A_CFG, cfg);
    endtask

    // records the first expiry pulses seen over len cycles
    task automatic span(input int len);
        ar = -1;
        ap = -1;
        for (int i = 0; i < len; i++) begin
            @(posedge clk);
            if (dev_rst === 1'b1 && ar < 0) ar = i;
            if (pcs === 1'b1 && ap < 0) ap = i;
        end
    endtask

    task automatic win(input string nm, input int at, input int lo, input int hi);
        check(nm, {31'h0, at >= lo && at <= hi}, 32'h1);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        {paddr, pwdata} = '0;
        // psel penable pwrite ext_n core_t high_t xtal_t irc_t
        {psel, penable, pwrite, ext_n, core_t, high_t, xtal_t, irc_t} = 8'h15;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdc("control", A_CTL, 32'hFFFFFFFF, 32'h7A);
        rdc("config", A_CFG, 32'hFFFFFFFF, 32'h0);
        rdc("enabled", A_STS, 32'h11, 32'h10);
        apb(1'b0, 8'h0C, 32'h0);
        check("slverr", {31'h0, err}, 32'h1);
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, A_CTL, {25'h0, c[2:0], 4'h5});
            rdc("select", A_CTL, 32'hFFFFFFFF, {25'h0, c[2:0], 4'h5});
        end
        setup(32'h15, 32'h02);
        u_core.issue(OP_SINGLE);
        span(16600);
        check("rc timeout", ar, 32'h4000);
        rdc("expired", A_STS, 32'h1, 32'h1);
        setup(32'h05, 32'h00);
        xtal_t <= 1'b1;
        irc_t  <= 1'b0;
        u_core.issue(OP_SINGLE);
        span(4200);
        ext_n <= 1'b0;
        repeat (2) @(posedge clk);
        ext_n <= 1'b1;
        span(4200);
        check("pin clear", ar, -1);
        u_core.issue(OP_SINGLE);
        span(4500);
        check("single clear", ar, -1);
        setup(32'h0A, 32'h08);
        rdc("disabled", A_STS, 32'h10, 32'h0);
        span(5000);
        check("disabled run", ar, -1);
        u_core.issue(OP_DEEP);
        u_core.issue(OP_WAKE);
        u_core.issue(OP_SINGLE);
        rdc("disabled clear", A_STS, 32'h2, 32'h2);
        apb(1'b1, A_CTL, 32'h05);
        rdc("key enable", A_STS, 32'h10, 32'h10);
        setup(32'h05, 32'h04);
        u_core.issue(OP_FIRST);
        span(4000);
        u_core.issue(OP_FIRST);
        span(4400);
        win("paired repeat", ar, 4180, 4200);
        setup(32'h05, 32'h04);
        u_core.issue(OP_SECOND);
        span(4500);
        u_core.issue(OP_FIRST);
        span(4500);
        check("paired alternate", ar, -1);
        setup(32'h05, 32'h10);
        u_core.issue(OP_DEEP);
        @(posedge clk);
        check("deep", {30'h0, run, clk_on}, 32'h0);
        rdc("pdown", A_STS, 32'h3, 32'h2);
        span(8400);
        win("sleep expiry", ap, 8170, 8200);
        check("sleep no reset", ar, -1);
        rdc("sleep flags", A_STS, 32'h3, 32'h3);
        u_core.issue(OP_DEEP);
        u_core.issue(OP_WAKE);
        @(posedge clk);
        check("wake clock", {30'h0, run, clk_on}, 32'h1);
        for (n = 0; n < 1100 && run !== 1'b1; n++) @(posedge clk);
        check("wake run", {30'h0, run, slow}, 32'h3);
        rdc("startup order", A_STS, 32'hC, 32'h4);
        u_core.issue(OP_SINGLE);
        rdc("pdown clear", A_STS, 32'h2, 32'h0);
        u_core.issue(OP_IDLE);
        @(posedge clk);
        check("idle off", {30'h0, run, clk_on}, 32'h0);
        u_core.issue(OP_WAKE);
        setup(32'h85, 32'h01);
        core_t <= 1'b1;
        xtal_t <= 1'b0;
        u_core.issue(OP_IDLE);
        @(posedge clk);
        check("idle", {30'h0, run, clk_on}, 32'h1);
        span(33000);
        win("core div4", ap, 32750, 32790);
        check("idle no reset", ar, -1);
        end_sim();
    end
endmodule

// file: tb/wdtu_core_model.sv
// model of the cpu core issuing clear, halt and wake instructions
`timescale 1ns/1ps
module wdtu_core_model (
    // clock
    input  wire logic            i_clk,
    // instruction pulses toward the watchdog
    output wdtu_pkg::wdtu_instr_t o_instr
);
    initial o_instr = '0;

    // one instruction lasts exactly one cycle, then the bus returns to idle
    task automatic issue(input logic [5:0] code);
        @(posedge i_clk);
        o_instr <= wdtu_pkg::wdtu_instr_t'(code);
        @(posedge i_clk);
        o_instr <= '0;
    endtask
endmodule

// file: tb/wdtu_props.sv
// assertion checker on the ports of the watchdog timer unit
`timescale 1ns/1ps
module wdtu_props (
    // clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_sys_rst,
    // apb
    input  wire logic                  i_psel,
    input  wire logic                  i_penable,
    input  wire logic [7:0]            i_paddr,
    input  wire logic                  o_pready,
    input  wire logic [31:0]           o_prdata,
    input  wire logic                  o_pslverr,
    // core side
    input  wire wdtu_pkg::wdtu_instr_t i_instr,
    input  wire logic                  o_device_reset,
    input  wire logic                  o_pc_stack_clear,
    input  wire logic                  o_core_run,
    input  wire logic                  o_core_clock_on
);
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);
    logic mapped;
    assign mapped = i_paddr inside {wdtu_pkg::ADDR_CONTROL, wdtu_pkg::ADDR_STATUS, wdtu_pkg::ADDR_CONFIG};

    a_apb_answer: assert property (i_psel && !i_penable |=> o_pready)
        else $error("no answer one cycle after setup");
    a_pready_single: assert property (o_pready |=> !o_pready)
        else $error("ready held longer than one cycle");
    a_pready_access: assert property (o_pready |-> i_psel && i_penable)
        else $error("ready outside an access phase");
    a_slverr_decode: assert property (o_pready |-> o_pslverr == !mapped)
        else $error("error response does not match address decode");
    a_err_no_data: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
        else $error("error response carries data");
    a_reset_single: assert property (o_device_reset |=> !o_device_reset)
        else $error("device reset longer than one cycle");
    a_expiry_kinds: assert property (!(o_device_reset && o_pc_stack_clear))
        else $error("both expiry actions at once");
    a_deep_clock_off: assert property (i_instr.halt && !i_instr.idle_sel && o_core_run |=> !o_core_run && !o_core_clock_on)
        else $error("deep sleep left core clock running");
    a_idle_core_stop: assert property (i_instr.halt && i_instr.idle_sel && o_core_run |=> !o_core_run)
        else $error("idle halt left core running");
    a_wake_clock: assert property (i_instr.wake && !o_core_clock_on |=> o_core_clock_on)
        else $error("wake did not restart core clock");
    a_reset_quiet: assert property ($past(i_sys_rst) |-> !o_pready && !o_device_reset && o_core_run && o_core_clock_on)
        else $error("outputs wrong after reset");
endmodule

bind wdtu_top wdtu_props u_props (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable), .i_paddr(i_paddr),
    .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_instr(i_instr),
    .o_device_reset(o_device_reset), .o_pc_stack_clear(o_pc_stack_clear), .o_core_run(o_core_run),
    .o_core_clock_on(o_core_clock_on)
);
